// ==== src/asc_control.sv ====
// second control register of the converter and its sequencing logic
// Operation
// - 3-bit reference code: 001 ext positive, 010 ext negative, else supply
// - scan bit set steps channel zero inputs during first sample
// - channel count 1x converts four channels, 00 channel zero; zero in 12b
// - status bit reads 1 while filling second half in split mode
// - step or interrupt after every n+1 completed conversions
// - split mode alternates halves per interrupt, else restart at start
// - alternate bit set toggles input select set each sample
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_control
    import asc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic conv_done,
    input wire logic sample_start,
    output logic [1:0] ref_sel,
    output logic scan_active,
    output logic four_channels,
    output logic use_set_b,
    output logic [3:0] buf_addr,
    output logic buf_second_half,
    output logic dma_step
);
    typedef struct packed {
        logic [15:0] ctrl2;
        logic twelve_bit_mode;
        logic wr_pend;
        logic rd_pend;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic [1:0] ref_sel;
        logic scan_active;
        logic four_channels;
        logic set_b;
        logic first_sample;
        logic half;
        logic [3:0] fill;
        logic [3:0] baddr;
        logic step;
    } asc_ctl_s;
    asc_ctl_s st, next_st;
    asc_sample_if sif();
    logic [15:0] ctrl2_view;
    logic ctrl2_wr;
    // only a write of control two restarts the conversion count
    assign ctrl2_wr = st.wr_pend && (st.addr == `ASC_CTRL2_OFFSET);
    // ============================================================
    // helpers
    function automatic asc_ref_e ref_decode(input logic [2:0] code);
        case (code)
            3'h1: ref_decode = ASC_REF_EXT_POS;
            3'h2: ref_decode = ASC_REF_EXT_NEG;
            default: ref_decode = ASC_REF_SUPPLY;
        endcase
    endfunction
    // ============================================================
    // counter of completed conversions
    assign sif.done = conv_done;
    assign sif.rate = st.ctrl2[`ASC_CONVS_PER_STEP_HI:`ASC_CONVS_PER_STEP_LO];
    asc_step_counter u_cnt (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(ctrl2_wr),
        .sif(sif)
    );
    // register view: channel count reads zero in twelve-bit mode
    always_comb begin
        ctrl2_view = st.ctrl2;
        if (st.twelve_bit_mode) begin
            ctrl2_view[`ASC_CHANNEL_COUNT_HI:`ASC_CHANNEL_COUNT_LO] = 2'h0;
        end
        ctrl2_view[`ASC_HALF_FILL_STATUS_BIT] =
            st.ctrl2[`ASC_SPLIT_BUFFER_MODE_BIT] & st.half;
    end
    // ============================================================
    // bus slave and sequencing
    always_comb begin
        next_st = st;
        next_st.wr_pend = 1'b0;
        next_st.rd_pend = 1'b0;
        next_st.step = sif.step;
        // write data phase; unmapped bits dropped by the mask
        if (st.wr_pend) begin
            case (st.addr)
                `ASC_CTRL2_OFFSET: begin
                    next_st.ctrl2 = hwdata[15:0] & `ASC_CTRL2_WMASK;
                    next_st.half = 1'b0;
                    next_st.fill = 4'h0;
                end
                `ASC_MODE_OFFSET: begin
                    next_st.twelve_bit_mode = hwdata[`ASC_MODE_12B_BIT];
                end
                default: begin
                end
            endcase
        end
        // address phase
        if (hsel && hready && htrans[1]) begin
            next_st.addr = haddr[7:0];
            next_st.wr_pend = hwrite;
            next_st.rd_pend = !hwrite;
            case (haddr[7:0])
                `ASC_CTRL2_OFFSET: next_st.rdata = {16'h0000, ctrl2_view};
                `ASC_MODE_OFFSET:
                    next_st.rdata = {31'h0, st.twelve_bit_mode};
                `ASC_STATUS_OFFSET:
                    next_st.rdata = {27'h0, st.half, st.fill};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
        next_st.ref_sel = 2'(ref_decode(st.ctrl2[`ASC_REF_HI:`ASC_REF_LO]));
        next_st.four_channels = !st.twelve_bit_mode
            && st.ctrl2[`ASC_CHANNEL_COUNT_HI];
        // sample sequencing
        if (sample_start) begin
            next_st.scan_active = st.ctrl2[`ASC_SCAN_BIT]
                && st.first_sample;
            next_st.first_sample = 1'b0;
            if (st.ctrl2[`ASC_ALTERNATE_SAMPLE_BIT]) begin
                next_st.set_b = !st.set_b;
            end else begin
                next_st.set_b = 1'b0;
            end
        end
        if (!st.ctrl2[`ASC_ALTERNATE_SAMPLE_BIT]) begin
            next_st.set_b = 1'b0;
        end
        // scanning stops as soon as the enable is cleared
        if (!st.ctrl2[`ASC_SCAN_BIT]) begin
            next_st.scan_active = 1'b0;
        end
        // buffer fill position advances per completed conversion
        if (conv_done) begin
            next_st.fill = st.fill + 4'h1;
        end
        if (sif.step) begin
            next_st.first_sample = 1'b1;
            if (st.ctrl2[`ASC_SPLIT_BUFFER_MODE_BIT]) begin
                next_st.half = !st.half;
                next_st.fill = 4'h0;
            end else begin
                next_st.half = 1'b0;
                next_st.fill = 4'h0;
            end
        end
        if (st.wr_pend && st.addr == `ASC_CTRL2_OFFSET) begin
            next_st.first_sample = 1'b1;
        end
        // buffer address registered so the port comes from a flop
        next_st.baddr = next_st.half ? (next_st.fill | `ASC_BUF_HALF)
            : next_st.fill;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.first_sample <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
    // ============================================================
    // outputs from flops, except hreadyout and hresp which are tied constant
    assign hrdata = st.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ref_sel = st.ref_sel;
    assign scan_active = st.scan_active;
    assign four_channels = st.four_channels;
    assign use_set_b = st.set_b;
    assign buf_addr = st.baddr;
    assign buf_second_half = st.half;
    assign dma_step = st.step;
endmodule

// ==== src/asc_regs.svh ====
// register offsets, field positions and reset values for the sequence control
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_CTRL2_OFFSET 8'h00
`define ASC_MODE_OFFSET 8'h04
`define ASC_STATUS_OFFSET 8'h08
`define ASC_CTRL2_RESET 16'h0000
`define ASC_CTRL2_WMASK 16'he73f
`define ASC_REF_HI 15
`define ASC_REF_LO 13
`define ASC_SCAN_BIT 10
`define ASC_CHANNEL_COUNT_HI 9
`define ASC_CHANNEL_COUNT_LO 8
`define ASC_HALF_FILL_STATUS_BIT 7
`define ASC_CONVS_PER_STEP_HI 5
`define ASC_CONVS_PER_STEP_LO 2
`define ASC_SPLIT_BUFFER_MODE_BIT 1
`define ASC_ALTERNATE_SAMPLE_BIT 0
`define ASC_MODE_12B_BIT 0
`define ASC_BUF_HALF 4'h8
`endif

// ==== src/asc_pkg.sv ====
// types shared by the sequence control modules
package asc_pkg;
    typedef enum logic [1:0] {
        ASC_REF_SUPPLY,
        ASC_REF_EXT_POS,
        ASC_REF_EXT_NEG
    } asc_ref_e;
    typedef logic [3:0] asc_count_t;
endpackage

// ==== src/asc_sample_if.sv ====
// samples finished and the step pulses back from the counter
`timescale 1ns/1ps
interface asc_sample_if;
    logic done;
    logic [3:0] rate;
    logic step;
    modport ctrl (output done, output rate, input step);
    modport cnt (input done, input rate, output step);
endinterface

// ==== src/asc_step_counter.sv ====
// counts completed conversions and pulses a step every rate+1 of them
`timescale 1ns/1ps
module asc_step_counter
    import asc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clear,
    asc_sample_if.cnt sif
);
    typedef struct packed {
        asc_count_t count;
    } asc_cnt_s;
    asc_cnt_s st, next_st;
    logic step_now;
    // ============================================================
    // counter; step leaves unregistered so the caller's flop is the only delay
    always_comb begin
        next_st = st;
        step_now = 1'b0;
        if (clear) begin
            next_st.count = 4'h0;
        end else if (sif.done) begin
            if (st.count >= sif.rate) begin
                next_st.count = 4'h0;
                step_now = 1'b1;
            end else begin
                next_st.count = st.count + 4'h1;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign sif.step = step_now;
endmodule

// ==== sim/asc_analog_model.sv ====
// far side model: one sample start, then its conversion end
`timescale 1ns/1ps
module asc_analog_model (
    input wire logic hclk,
    input wire logic go,
    input wire logic [2:0] lat,
    output logic sample_start,
    output logic conv_done
);
    logic busy;
    logic [2:0] t;
    initial begin
        {busy, t, sample_start, conv_done} = '0;
    end
    // lat sets a prompt or a slow conversion; go while busy is dropped
    always @(posedge hclk) begin
        sample_start <= go && !busy;
        conv_done <= busy && t == 3'h0;
        if (go && !busy) begin
            busy <= 1'b1;
            t <= lat;
        end else if (busy) begin
            t <= t - 3'h1;
            busy <= t != 3'h0;
        end
    end
endmodule

// ==== sim/asc_control_properties.sv ====
// port checks for the converter sequence control
`timescale 1ns/1ps
module asc_control_properties (
    input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout,
    input wire logic [31:0] haddr, hwdata, hrdata,
    input wire logic [1:0] htrans, ref_sel,
    input wire logic conv_done, sample_start, scan_active, four_channels,
    input wire logic use_set_b, buf_second_half, dma_step
);
    logic aw, ar, m12;
    logic [7:0] ao;
    logic [15:0] ctl;
    logic [4:0] cnt;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // shadow of the register rebuilt from bus traffic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {aw, ar, m12, ao, ctl, cnt} <= '0;
        end else begin
            aw <= hsel && hready && htrans[1] && hwrite;
            ar <= hsel && hready && htrans[1] && !hwrite;
            if (hsel && hready && htrans[1]) ao <= haddr[7:0];
            if (aw && ao == 8'h00) ctl <= hwdata[15:0] & 16'he73f;
            if (aw && ao == 8'h04) m12 <= hwdata[0];
            // a control two write restarts the conversion count
            if ((aw && ao == 8'h00) || dma_step) cnt <= {4'h0, conv_done};
            else cnt <= cnt + {4'h0, conv_done};
        end
    end
    AST_REF: assert property (ref_sel ==
        ($past(ctl[15:13]) == 3'h1 ? 2'h1 :
        $past(ctl[15:13]) == 3'h2 ? 2'h2 : 2'h0))
        else $error("bad ref select");
    AST_SCAN: assert property (!ctl[10] && $past(!ctl[10]) |->
        !scan_active) else $error("scan without enable");
    AST_CHAN: assert property (four_channels ==
        $past(ctl[9] && !m12)) else $error("bad channel count");
    AST_RD: assert property (ar && ao == 8'h00 |->
        hrdata[31:16] == 0 &&
        (hrdata[15:0] & 16'he47f) == ($past(ctl) & 16'he47f) &&
        ($past(m12) ? hrdata[9:8] == 2'h0 : hrdata[9:8] == $past(ctl[9:8])))
        else $error("bad control read");
    AST_HALF_RD: assert property (ar && ao == 8'h00 |->
        hrdata[7] == $past(ctl[1] && buf_second_half)) else $error("bad half");
    AST_STEP: assert property (dma_step |-> cnt == {1'b0, ctl[5:2]} + 5'h1)
        else $error("step at wrong count");
    AST_CNT: assert property (cnt <= {1'b0, ctl[5:2]} + 5'h1)
        else $error("step missed");
    AST_HALF: assert property (!ctl[1] && $past(!ctl[1]) |->
        !buf_second_half) else $error("half outside split mode");
    AST_ALT_OFF: assert property (!ctl[0] && $past(!ctl[0]) |-> !use_set_b)
        else $error("second set without alternate");
    AST_ALT: assert property (sample_start && ctl[0] && $past(ctl[0]) |=>
        use_set_b != $past(use_set_b)) else $error("no set toggle");
endmodule
bind asc_control asc_control_properties i_prop (.*);

// ==== sim/tb_adc_sequence_control.sv ====
// bench for the converter sequence control
`timescale 1ns/1ps
module tb_adc_sequence_control;
    import asc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, go, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans, ref_sel;
    logic [2:0] hsize, lat;
    logic [3:0] buf_addr;
    logic conv_done, sample_start, scan_active, four_channels;
    logic use_set_b, buf_second_half, dma_step;
    int fails, checked, steps;
    asc_control i_dut (.*);
    asc_analog_model i_adc (.hclk(hclk), .go(go), .lat(lat),
        .sample_start(sample_start), .conv_done(conv_done));
    initial begin
        hclk = 0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) if (dma_step === 1'b1) steps++;
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // one sample through the far side, then let it settle
    task automatic samp();
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        repeat (lat + 5) @(posedge hclk);
    endtask
    task automatic t_regs();
        bus(8'h00, 0, 0); chk("reset", 0, q);
        bus(8'h0c, 1, 32'hffffffff); bus(8'h0c, 0, 0); chk("unmapped", 0, q);
        bus(8'h00, 1, 32'hffffffff); bus(8'h00, 0, 0); chk("rw", 32'he73f, q);
        chk("four", 1, four_channels);
    endtask
    task automatic t_ref();
        for (int c = 0; c < 8; c++) begin
            bus(8'h00, 1, c << 13);
            repeat (2) @(posedge hclk);
            chk("ref", c == 1 ? 1 : c == 2 ? 2 : 0, ref_sel);
        end
    endtask
    task automatic t_wide();
        bus(8'h04, 1, 1); bus(8'h00, 1, 32'h0300); bus(8'h00, 0, 0);
        chk("chps12", 0, q); chk("four12", 0, four_channels);
        bus(8'h04, 1, 0);
    endtask
    // split buffer with n+1 conversions per step, prompt or slow far side
    task automatic t_step(input logic [3:0] n);
        lat <= n[2:0];
        bus(8'h00, 1, {26'h0, n, 2'h2});
        steps = 0;
        repeat (n + 1) samp();
        chk("steps", 1, steps);
        bus(8'h00, 0, 0); chk("half1", 1, q[7]);
        chk("baddr1", 32'h8, buf_addr);
        repeat (n + 1) samp();
        chk("steps2", 2, steps);
        bus(8'h00, 0, 0); chk("half0", 0, q[7]);
        chk("baddr0", 32'h0, buf_addr);
    endtask
    task automatic t_alt();
        bus(8'h00, 1, 32'h0401);
        samp();
        chk("scan", 1, scan_active);
        chk("setb", 1, use_set_b);
        repeat (2) samp();
        bus(8'h00, 0, 0); chk("nosplit", 0, q[7]);
        bus(8'h00, 1, 0);
        samp();
        chk("seta", 0, use_set_b);
    endtask
    task automatic end_sim();
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, go, hresetn} = '0;
        hsize = 3'h2;
        hready = 1'b1;
        lat = 3'h1;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs(); t_ref(); t_wide(); t_step(4'h0); t_step(4'hf); t_alt();
        end_sim();
    end
    // watchdog well past the six hundred or so cycles the tests need
    initial begin
        #200us;
        fails++;
        end_sim();
    end
endmodule
